// ---- common/bss_defs.svh ----
// register map, field positions and reset values of the supply supervisor
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define BSS_OFF_STATUS  8'h00
`define BSS_OFF_MASK    8'h04
`define BSS_OFF_CTRL    8'h08
`define BSS_OFF_MODE    8'h0C
`define BSS_OFF_LOSS_LO 8'h10
`define BSS_OFF_LOSS_HI 8'h14
`define BSS_OFF_RET_LO  8'h18
`define BSS_OFF_RET_HI  8'h1C

// ****************************************
// status and mask bit positions
// ****************************************
`define BSS_ST_W    6
`define BSS_ST_TPF  0
`define BSS_ST_BAT2 1
`define BSS_ST_BAT1 2
`define BSS_ST_LOW  3
`define BSS_ST_ENT  4
`define BSS_ST_RET  5

// ****************************************
// control bit positions
// ****************************************
`define BSS_CT_W       7
`define BSS_CT_SEL_LSB 0
`define BSS_CT_SEL_MSB 2
`define BSS_CT_TSE     3
`define BSS_CT_BATTERY_MODE_TEMP_ENABLE    4
`define BSS_CT_TIMESTAMP_CLEAR   5
`define BSS_CT_IODIS   6

// ****************************************
// reset values and limits
// ****************************************
`define BSS_ST_RST    6'h01
`define BSS_MASK_RST  6'h00
`define BSS_CT_RST    7'h00
`define BSS_BROWN_MAX 3'h5
`define BSS_WORD0     32'h0000_0000

`endif

// ---- common/bss_pkg.sv ----
// types shared by the supply supervisor modules
`default_nettype none
package bss_pkg;
   // supply mode, one-hot
   typedef enum logic [1:0] {
      BSS_MAIN = 2'b01,
      BSS_BATT = 2'b10
   } bss_mode_t;

   // comparator results from the analog monitors
   typedef struct packed {
      logic       below_bat_hys;
      logic       below_trip;
      logic       above_bat_hys;
      logic       above_trip_hys;
      logic       bat_below_85;
      logic       bat_below_75;
      logic [5:0] brown;
   } bss_cmp_t;
endpackage
`default_nettype wire

// ---- rtl/bss_sync.sv ----
// two-stage synchroniser for the comparator bundle
`default_nettype none
module bss_sync
   import bss_pkg::*;
(
   // clock and control
   input  wire logic     clock,
   input  wire logic     reset,
   input  wire logic     ce,
   // bundle in and out
   input  wire bss_cmp_t d,
   output var  bss_cmp_t q
);
   bss_cmp_t meta_r;

   // first stage feeds only the second
   always_ff @(posedge clock) begin
      if (reset) begin
         meta_r <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/bss_tstamp.sv ----
// time stamp holder, keep-first or keep-last
`default_nettype none
module bss_tstamp #(
   parameter int TS_W       = 40,
   parameter bit KEEP_FIRST = 1'b0
) (
   // clock and control
   input  wire logic            clock,
   input  wire logic            reset,
   input  wire logic            ce,
   // capture and clear
   input  wire logic            capture,
   input  wire logic            clear,
   input  wire logic [TS_W-1:0] now,
   // held stamp
   output logic      [TS_W-1:0] stamp,
   output logic                 valid
);
   logic take;

   // a capture beside a clear still lands: set wins
   assign take = capture && (!KEEP_FIRST || !valid || clear);

   always_ff @(posedge clock) begin
      if (reset) begin
         stamp <= '0;
         valid <= 1'b0;
      end else if (ce) begin
         if (take) begin
            stamp <= now;
            valid <= 1'b1;
         end else if (clear) begin
            stamp <= '0;
            valid <= 1'b0;
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   // a taken stamp shows the time at its capture edge
   property p_copy;
      @(posedge clock) disable iff (reset)
      ce && capture && (!KEEP_FIRST || !valid) |=> valid && stamp == $past(now);
   endproperty
   a_copy: assert property (p_copy)
      else $error("stamp not taken");

   // a held first stamp survives later captures until a clear
   property p_hold;
      @(posedge clock) disable iff (reset)
      valid && !clear && !(capture && !KEEP_FIRST) |=> valid && $stable(stamp);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stamp overwritten");

   property p_clear;
      @(posedge clock) disable iff (reset)
      ce && clear && !capture |=> !valid && stamp == '0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("stamp not cleared");
endmodule
`default_nettype wire

// ---- rtl/bss_top.sv ----
// backup supply supervisor with apb register file
//
// Function
// - enter battery mode below both thresholds
// - leave battery mode above either threshold
// - host bus disabled in battery mode
// - timekeeping keeps running, other io too unless io disable is set
// - supply loss copies time into stamp
// - first supply-loss stamp kept until cleared
// - supply return stamp always overwritten
// - clear write wipes time stamps
// - battery temp enable gates compensation
// - total power fail flag after power-up
// - six brownout levels set low flag
// - brownout alone keeps host bus active
// - battery levels set first, both flags
// - no battery monitoring in battery mode
//
// The address map and the APB register port were chosen for this implementation.
`include "bss_defs.svh"
`default_nettype none
module bss_top
   import bss_pkg::*;
#(
   parameter int TS_W = 40
) (
   // clock, reset, enable
   input  wire logic            clock,
   input  wire logic            reset,
   input  wire logic            ce,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // analog monitors and time
   input  wire bss_cmp_t        cmp_in,
   input  wire logic [TS_W-1:0] time_now,
   // supervisor outputs
   output logic                 battery_mode,
   output logic                 host_bus_enable,
   output logic                 timekeep_enable,
   output logic                 aux_io_enable,
   output logic                 temp_comp_enable,
   output logic                 total_power_fail_flag,
   output logic                 main_supply_low_flag,
   output logic                 battery_low_first_flag,
   output logic                 battery_low_second_flag,
   output logic                 irq
);

   // ****************************************
   // declarations
   // ****************************************
   bss_cmp_t             cmp_s;
   bss_mode_t            mode_r;
   bss_mode_t            mode_nxt;
   logic                 enter_p_r;
   logic                 leave_p_r;
   logic [`BSS_ST_W-1:0] status_r;
   logic [`BSS_ST_W-1:0] status_nxt;
   logic [`BSS_ST_W-1:0] set_vec;
   logic [`BSS_ST_W-1:0] mask_r;
   logic [`BSS_CT_W-1:0] ctrl_r;
   logic                 meas_go_r;
   logic                 clr_go_r;
   logic                 wr_go;
   logic                 rd_go;
   logic                 brown_hit;
   logic [2:0]           sel_c;
   logic [TS_W-1:0]      loss_ts;
   logic [TS_W-1:0]      ret_ts;
   logic                 loss_valid;
   logic                 ret_valid;

   // ****************************************
   // helper functions
   // ****************************************
   // true when the offset names a register
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `BSS_OFF_STATUS) || (a == `BSS_OFF_MASK)
            || (a == `BSS_OFF_CTRL) || (a == `BSS_OFF_MODE)
            || (a == `BSS_OFF_LOSS_LO) || (a == `BSS_OFF_LOSS_HI)
            || (a == `BSS_OFF_RET_LO) || (a == `BSS_OFF_RET_HI);
   endfunction

   // low or high word of a stamp, zero padded
   function automatic logic [31:0] ts_word(input logic [TS_W-1:0] t,
                                           input logic hi);
      logic [63:0] w;
      w = 64'h0000_0000_0000_0000;
      w[TS_W-1:0] = t;
      ts_word = hi ? w[63:32] : w[31:0];
   endfunction

   // ****************************************
   // comparator synchroniser
   // ****************************************
   bss_sync u_sync (
      .clock (clock),
      .reset (reset),
      .ce    (ce),
      .d     (cmp_in),
      .q     (cmp_s)
   );

   // ****************************************
   // supply mode machine
   // ****************************************
   // next mode from the synchronised comparators
   always_comb begin
      case (mode_r)
         BSS_MAIN: mode_nxt = (cmp_s.below_bat_hys && cmp_s.below_trip)
                            ? BSS_BATT : BSS_MAIN;
         BSS_BATT: mode_nxt = (cmp_s.above_bat_hys || cmp_s.above_trip_hys)
                            ? BSS_MAIN : BSS_BATT;
         default:  mode_nxt = BSS_MAIN;
      endcase
   end

   // registered mode gives one pulse per transition
   always_ff @(posedge clock) begin
      if (reset) begin
         mode_r    <= BSS_MAIN;
         enter_p_r <= 1'b0;
         leave_p_r <= 1'b0;
      end else if (ce) begin
         mode_r    <= mode_nxt;
         enter_p_r <= (mode_r == BSS_MAIN) && (mode_nxt == BSS_BATT);
         leave_p_r <= (mode_r == BSS_BATT) && (mode_nxt == BSS_MAIN);
      end
   end

   // ****************************************
   // time stamps
   // ****************************************
   // supply loss keeps the earliest stamp
   bss_tstamp #(.TS_W(TS_W), .KEEP_FIRST(1'b1)) u_loss (
      .clock   (clock),
      .reset   (reset),
      .ce      (ce),
      .capture (enter_p_r),
      .clear   (clr_go_r),
      .now     (time_now),
      .stamp   (loss_ts),
      .valid   (loss_valid)
   );

   // supply return keeps the latest stamp
   bss_tstamp #(.TS_W(TS_W), .KEEP_FIRST(1'b0)) u_ret (
      .clock   (clock),
      .reset   (reset),
      .ce      (ce),
      .capture (leave_p_r),
      .clear   (clr_go_r),
      .now     (time_now),
      .stamp   (ret_ts),
      .valid   (ret_valid)
   );

   // ****************************************
   // apb decode
   // ****************************************
   // pready is high only in the access cycle, no wait states
   assign wr_go = psel && penable && pready && pwrite;
   assign rd_go = psel && penable && pready && !pwrite;

   always_ff @(posedge clock) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `BSS_WORD0;
      end else if (ce) begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `BSS_OFF_STATUS:  prdata <= {26'h0, status_r};
               `BSS_OFF_MASK:    prdata <= {26'h0, mask_r};
               `BSS_OFF_CTRL:    prdata <= {25'h0, ctrl_r};
               `BSS_OFF_MODE:    prdata <= {29'h0, ret_valid, loss_valid,
                                            mode_r == BSS_BATT};
               `BSS_OFF_LOSS_LO: prdata <= ts_word(loss_ts, 1'b0);
               `BSS_OFF_LOSS_HI: prdata <= ts_word(loss_ts, 1'b1);
               `BSS_OFF_RET_LO:  prdata <= ts_word(ret_ts, 1'b0);
               `BSS_OFF_RET_HI:  prdata <= ts_word(ret_ts, 1'b1);
               default:          prdata <= `BSS_WORD0;
            endcase
         end
      end
   end

   // ****************************************
   // control and mask registers
   // ****************************************
   // clear and measure are one-cycle strobes; the clear bit is never stored, the measure bit stays in ctrl_r
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_r    <= `BSS_CT_RST;
         mask_r    <= `BSS_MASK_RST;
         meas_go_r <= 1'b0;
         clr_go_r  <= 1'b0;
      end else if (ce) begin
         meas_go_r <= 1'b0;
         clr_go_r  <= 1'b0;
         if (wr_go && paddr == `BSS_OFF_MASK) begin
            mask_r <= pwdata[`BSS_ST_W-1:0];
         end
         if (wr_go && paddr == `BSS_OFF_CTRL) begin
            ctrl_r <= pwdata[`BSS_CT_W-1:0];
            ctrl_r[`BSS_CT_TIMESTAMP_CLEAR] <= 1'b0;
            clr_go_r  <= pwdata[`BSS_CT_TIMESTAMP_CLEAR];
            // a measurement in battery mode would be meaningless
            meas_go_r <= pwdata[`BSS_CT_TSE] && (mode_r == BSS_MAIN);
         end
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   // out-of-range level selects fall back to the top level
   assign sel_c = (ctrl_r[`BSS_CT_SEL_MSB:`BSS_CT_SEL_LSB] > `BSS_BROWN_MAX)
                ? `BSS_BROWN_MAX : ctrl_r[`BSS_CT_SEL_MSB:`BSS_CT_SEL_LSB];
   assign brown_hit = cmp_s.brown[sel_c];

   // events of this cycle
   always_comb begin
      set_vec               = '0;
      set_vec[`BSS_ST_LOW]  = brown_hit;
      set_vec[`BSS_ST_BAT1] = meas_go_r && (cmp_s.bat_below_85
                                         || cmp_s.bat_below_75);
      set_vec[`BSS_ST_BAT2] = meas_go_r && cmp_s.bat_below_75;
      set_vec[`BSS_ST_ENT]  = enter_p_r;
      set_vec[`BSS_ST_RET]  = leave_p_r;
   end

   // read of the status word clears it, but a new event wins
   always_comb begin
      status_nxt = status_r;
      if (rd_go && paddr == `BSS_OFF_STATUS) begin
         status_nxt = '0;
      end
      status_nxt = status_nxt | set_vec;
   end

   // reset stands for power-up after total loss
   always_ff @(posedge clock) begin
      if (reset) begin
         status_r <= `BSS_ST_RST;
      end else if (ce) begin
         status_r <= status_nxt;
      end
   end

   // ****************************************
   // output flops
   // ****************************************
   // every output is a flop, one cycle behind its cause
   always_ff @(posedge clock) begin
      if (reset) begin
         battery_mode     <= 1'b0;
         host_bus_enable  <= 1'b1;
         timekeep_enable  <= 1'b1;
         aux_io_enable    <= 1'b1;
         temp_comp_enable <= 1'b1;
         irq              <= 1'b0;
      end else if (ce) begin
         battery_mode     <= mode_r == BSS_BATT;
         // brownout plays no part here
         host_bus_enable  <= mode_r == BSS_MAIN;
         timekeep_enable  <= 1'b1;
         aux_io_enable    <= !(mode_r == BSS_BATT && ctrl_r[`BSS_CT_IODIS]);
         temp_comp_enable <= mode_r == BSS_MAIN || ctrl_r[`BSS_CT_BATTERY_MODE_TEMP_ENABLE];
         irq              <= |(status_r & mask_r);
      end
   end

   // flags mirror the status bits
   always_ff @(posedge clock) begin
      if (reset) begin
         total_power_fail_flag   <= 1'b1;
         main_supply_low_flag    <= 1'b0;
         battery_low_first_flag  <= 1'b0;
         battery_low_second_flag <= 1'b0;
      end else if (ce) begin
         total_power_fail_flag   <= status_nxt[`BSS_ST_TPF];
         main_supply_low_flag    <= status_nxt[`BSS_ST_LOW];
         battery_low_first_flag  <= status_nxt[`BSS_ST_BAT1];
         battery_low_second_flag <= status_nxt[`BSS_ST_BAT2];
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   sequence s_main_trip;
      ce && mode_r == BSS_MAIN && cmp_s.below_bat_hys && cmp_s.below_trip;
   endsequence

   property p_enter_batt;
      @(posedge clock) disable iff (reset)
      s_main_trip |=> mode_r == BSS_BATT && enter_p_r;
   endproperty
   a_enter_batt: assert property (p_enter_batt)
      else $error("battery mode not entered");

   property p_leave_batt;
      @(posedge clock) disable iff (reset)
      ce && mode_r == BSS_BATT && (cmp_s.above_bat_hys || cmp_s.above_trip_hys)
      |=> mode_r == BSS_MAIN && leave_p_r;
   endproperty
   a_leave_batt: assert property (p_leave_batt)
      else $error("battery mode not left");

   property p_bus_off;
      @(posedge clock) disable iff (reset)
      ce |=> host_bus_enable == ($past(mode_r) == BSS_MAIN);
   endproperty
   a_bus_off: assert property (p_bus_off)
      else $error("host bus enable wrong");

   property p_loss_copy;
      @(posedge clock) disable iff (reset)
      !loss_valid ##0 s_main_trip ##1 ce
      |=> loss_valid && loss_ts == $past(time_now);
   endproperty
   a_loss_copy: assert property (p_loss_copy)
      else $error("loss stamp not taken");

   property p_temp_comp;
      @(posedge clock) disable iff (reset)
      ce |=> temp_comp_enable
         == ($past(mode_r) == BSS_MAIN || $past(ctrl_r[`BSS_CT_BATTERY_MODE_TEMP_ENABLE]));
   endproperty
   a_temp_comp: assert property (p_temp_comp)
      else $error("compensation enable wrong");

   property p_brown;
      @(posedge clock) disable iff (reset)
      ce && brown_hit |=> status_r[`BSS_ST_LOW] && main_supply_low_flag;
   endproperty
   a_brown: assert property (p_brown)
      else $error("brownout flag missed");

   property p_bat_both;
      @(posedge clock) disable iff (reset)
      ce && meas_go_r && cmp_s.bat_below_75
      |=> battery_low_first_flag && battery_low_second_flag;
   endproperty
   a_bat_both: assert property (p_bat_both)
      else $error("battery flags not both set");

   property p_no_meas_batt;
      @(posedge clock) disable iff (reset)
      ce && mode_r == BSS_BATT |=> !meas_go_r;
   endproperty
   a_no_meas_batt: assert property (p_no_meas_batt)
      else $error("measurement in battery mode");

endmodule
`default_nettype wire

// ---- bench/bss_cmp_model.sv ----
// comparator model standing in for the supply and battery monitors
`default_nettype none
module bss_cmp_model
   import bss_pkg::*;
#(
   parameter int HYS_BAT   = 50,
   parameter int TRIP      = 2200,
   parameter int HYS_TRIP  = 30,
   parameter int NOM       = 3000,
   parameter int LVL [6]   = '{3100, 3000, 2900, 2800, 2700, 2600}
) (
   // supply levels in millivolts
   input  wire logic [15:0] vdd_mv,
   input  wire logic [15:0] bat_mv,
   // comparator bundle
   output var  bss_cmp_t    cmp
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************
   // ideal comparators, no noise or delay
   // ************************************
   // ideal levels keep the test exact; real monitors chatter near the trip
   always_comb begin
      cmp.below_bat_hys  = int'(vdd_mv) < int'(bat_mv) - HYS_BAT;
      cmp.below_trip     = int'(vdd_mv) < TRIP;
      cmp.above_bat_hys  = int'(vdd_mv) > int'(bat_mv) + HYS_BAT;
      cmp.above_trip_hys = int'(vdd_mv) > TRIP + HYS_TRIP;
      cmp.bat_below_85   = int'(bat_mv) * 100 < NOM * 85;
      cmp.bat_below_75   = int'(bat_mv) * 100 < NOM * 75;
      for (int i = 0; i < 6; i++) begin
         cmp.brown[i] = int'(vdd_mv) < LVL[i];
      end
   end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the backup supply supervisor
`include "bss_defs.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bss_pkg::*;
   localparam int LVL [6] = '{3100, 3000, 2900, 2800, 2700, 2600};
   localparam logic [39:0] T1 = 40'h12_0000_0011, T2 = 40'h34_0000_0022;
   localparam logic [39:0] T3 = 40'h56_0000_0033, T4 = 40'h78_0000_0044;
   // ************************************
   // stimulus and observed signals
   // ************************************
   logic        clock = 1'b0;
   logic        reset, ce, psel, penable, pwrite, pready, pslverr, battery_mode;
   logic        host_bus_enable, timekeep_enable, aux_io_enable, temp_comp_enable;
   logic        total_power_fail_flag, main_supply_low_flag, irq;
   logic        battery_low_first_flag, battery_low_second_flag;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] vdd, bat;
   logic [39:0] tnow;
   logic        er;
   bss_cmp_t    cmp;
   int          mismatches = 0;
   int          compares = 0;

   always #25 clock = ~clock;

   bss_cmp_model #(.LVL(LVL)) i_bss_cmp_model (.vdd_mv(vdd), .bat_mv(bat), .cmp(cmp));

   bss_top #(.TS_W(40)) i_bss_top (
      .clock(clock), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_in(cmp), .time_now(tnow),
      .battery_mode(battery_mode), .host_bus_enable(host_bus_enable),
      .timekeep_enable(timekeep_enable), .aux_io_enable(aux_io_enable),
      .temp_comp_enable(temp_comp_enable),
      .total_power_fail_flag(total_power_fail_flag),
      .main_supply_low_flag(main_supply_low_flag),
      .battery_low_first_flag(battery_low_first_flag),
      .battery_low_second_flag(battery_low_second_flag), .irq(irq));

   // ************************************
   // tasks
   // ************************************
   task automatic close_out();
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wcyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 1, pready);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // mode change is bounded; a stuck mode shows up as a mismatch
   task automatic wait_mode(input logic v);
      int n;
      n = 0;
      while (battery_mode !== v && n < 20) begin
         @(posedge clock);
         n++;
      end
      chk("battery_mode", v, battery_mode);
   endtask

   task automatic chk_stamp(input logic [7:0] a, input logic [39:0] e);
      apb(1'b0, a, 32'h0);
      chk("stamp_lo", e[31:0], rd);
      apb(1'b0, a + 8'h04, 32'h0);
      chk("stamp_hi", {32'h0, e[39:32]}, rd);
   endtask

   // ************************************
   // main sequence
   // ************************************
   initial begin
      reset = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; vdd = 16'd3300; bat = 16'd3000; tnow = 40'h0;
      wcyc(4);
      reset <= 1'b0;
      wcyc(1);
      chk("total_power_fail_flag", 1, total_power_fail_flag);
      apb(1'b0, `BSS_OFF_STATUS, 32'h0); chk("status", 32'h01, rd);
      apb(1'b0, `BSS_OFF_STATUS, 32'h0); chk("status", 32'h00, rd);
      apb(1'b0, 8'h20, 32'h0); chk("pslverr", 1, er);
      chk("unmapped", 0, rd);
      // every brownout level, just above and just below
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `BSS_OFF_CTRL, i);
         vdd <= 16'(LVL[i] + 10);
         wcyc(6);
         apb(1'b0, `BSS_OFF_STATUS, 32'h0);
         wcyc(6);
         chk("main_supply_low_flag", 0, main_supply_low_flag);
         vdd <= 16'(LVL[i] - 10);
         wcyc(6);
         chk("main_supply_low_flag", 1, main_supply_low_flag);
         chk("host_bus_enable", 1, host_bus_enable);
      end
      // battery levels only after a measurement request
      vdd <= 16'd3300; bat <= 16'd2400;
      wcyc(8);
      apb(1'b0, `BSS_OFF_STATUS, 32'h0);
      wcyc(2);
      chk("battery_low_first_flag", 0, battery_low_first_flag);
      apb(1'b1, `BSS_OFF_CTRL, 32'h08);
      wcyc(8);
      chk("battery_low_first_flag", 1, battery_low_first_flag);
      chk("battery_low_second_flag", 0, battery_low_second_flag);
      bat <= 16'd2000;
      wcyc(6);
      apb(1'b1, `BSS_OFF_CTRL, 32'h08);
      wcyc(8);
      chk("battery_low_second_flag", 1, battery_low_second_flag);
      chk("battery_low_first_flag", 1, battery_low_first_flag);
      apb(1'b1, `BSS_OFF_CTRL, 32'h00);
      // one condition alone never switches
      vdd <= 16'd2100;
      wcyc(8);
      chk("battery_mode", 0, battery_mode);
      vdd <= 16'd2500; bat <= 16'd3000;
      wcyc(8);
      chk("battery_mode", 0, battery_mode);
      tnow <= T1; vdd <= 16'd1900;
      wait_mode(1'b1);
      chk("host_bus_enable", 0, host_bus_enable);
      chk("timekeep_enable", 1, timekeep_enable);
      chk("aux_io_enable", 1, aux_io_enable);
      chk("temp_comp_enable", 0, temp_comp_enable);
      tnow <= T2; vdd <= 16'd2240;
      wait_mode(1'b0);
      chk("host_bus_enable", 1, host_bus_enable);
      chk_stamp(`BSS_OFF_LOSS_LO, T1);
      chk_stamp(`BSS_OFF_RET_LO, T2);
      tnow <= T3; vdd <= 16'd1900;
      wait_mode(1'b1);
      tnow <= T4; vdd <= 16'd2100; bat <= 16'd2000;
      wait_mode(1'b0);
      chk_stamp(`BSS_OFF_LOSS_LO, T1);
      chk_stamp(`BSS_OFF_RET_LO, T4);
      // interrupt on the switch event, masked in, cleared by the read
      apb(1'b1, `BSS_OFF_MASK, 32'h10);
      apb(1'b0, `BSS_OFF_MASK, 32'h0); chk("mask", 32'h10, rd);
      wcyc(2);
      chk("irq", 1, irq);
      apb(1'b0, `BSS_OFF_STATUS, 32'h0); chk("status", 32'h30, rd & 32'h30);
      wcyc(2);
      chk("irq", 0, irq);
      // battery temperature and io disable honoured in backup
      apb(1'b1, `BSS_OFF_CTRL, 32'h50);
      // a low enable freezes the mode machine even with the supply gone
      ce <= 1'b0; vdd <= 16'd1900; bat <= 16'd3000;
      wcyc(8);
      chk("battery_mode", 0, battery_mode);
      ce <= 1'b1;
      wait_mode(1'b1);
      chk("temp_comp_enable", 1, temp_comp_enable);
      chk("aux_io_enable", 0, aux_io_enable);
      // a measurement request in backup leaves the battery flags alone
      bat <= 16'd2000;
      apb(1'b1, `BSS_OFF_CTRL, 32'h58);
      wcyc(8);
      chk("battery_low_first_flag", 0, battery_low_first_flag);
      vdd <= 16'd3300;
      wait_mode(1'b0);
      chk_stamp(`BSS_OFF_LOSS_LO, T1);
      apb(1'b1, `BSS_OFF_CTRL, 32'h20);
      chk_stamp(`BSS_OFF_LOSS_LO, 40'h0);
      chk_stamp(`BSS_OFF_RET_LO, 40'h0);
      apb(1'b0, `BSS_OFF_MODE, 32'h0); chk("mode", 32'h0, rd & 32'h6);
      close_out();
   end

   // watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #(50 * 4000);
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
